// ---- logic/dmaic_pkg.sv ----
// constants, types and register map shared by both ends of the dma control block
package dmaic_pkg;
  localparam int NCH = 6;
  localparam int DW  = 8;
  localparam int AW  = 4;
  // -----------------------------------------------------------------
  // device register indexes
  // -----------------------------------------------------------------
  localparam logic [AW-1:0] A_CTRL0 = 4'h0;
  localparam logic [AW-1:0] A_MODE  = 4'h6;
  localparam logic [AW-1:0] A_ROUTE = 4'h7;
  localparam logic [AW-1:0] A_MAR0  = 4'h8;
  localparam logic [AW-1:0] A_STAT  = 4'he;
  localparam logic [AW-1:0] A_IRQ   = 4'hf;
  // channel control fields
  localparam int B_IE = 0, B_XE = 1, B_ME = 2, B_SC = 3, B_INT = 4, B_EDGE = 5, B_BURST = 6;
  // mode fields
  localparam int M_SHARED = 0, M_FULL = 1, M_SAE = 2, M_TEE = 3, M_WBE = 4, M_STOP = 5;
  // route fields
  localparam int R_ONE = 0, R_FOUR = 1, R_THREE = 2, R_FIVE = 3, R_P0 = 4, R_P1 = 5;
  localparam logic [DW-1:0] CTRL_RST  = 8'h00;
  localparam logic [DW-1:0] MODE_RST  = 8'h01;
  localparam logic [DW-1:0] ROUTE_RST = 8'h00;
  // channel service order, highest first
  localparam int PRIO [NCH] = '{0, 1, 4, 2, 3, 5};
  // -----------------------------------------------------------------
  // host register addresses
  // -----------------------------------------------------------------
  localparam logic [AW:0] H_REFUSED = 5'h10;
  localparam logic [AW:0] H_IRQ     = 5'h11;
  localparam logic [AW:0] H_PASS    = 5'h12;
  localparam int F_RL6 = 0, F_RL7 = 1, F_RL12 = 2;
  typedef enum logic [2:0] {ENG_IDLE = 3'h1, ENG_ADDR = 3'h2, ENG_BUS = 3'h4} dmaic_eng_t;
  typedef enum logic [2:0] {DET_LOW = 3'h1, DET_XFER = 3'h2, DET_HIGH = 3'h4} dmaic_det_t;
endpackage : dmaic_pkg

// ---- logic/dmaic_if.sv ----
// register and event link between the host end and the dma control end
`timescale 1ns/10ps
interface dmaic_if;
  logic                          rd;
  logic                          wr;
  logic [dmaic_pkg::AW-1:0]      addr;
  logic [dmaic_pkg::DW-1:0]      wdata;
  logic [dmaic_pkg::DW-1:0]      rdata;
  logic [7:0]                    irq;
  logic [dmaic_pkg::NCH-1:0]     chan_en;
  logic                          ext_busy;
  logic [dmaic_pkg::NCH-1:0]     int_pass;
  modport dev  (input rd, wr, addr, wdata, output rdata, irq, chan_en, ext_busy, int_pass);
  modport host (output rd, wr, addr, wdata, input rdata, irq, chan_en, ext_busy, int_pass);
endinterface : dmaic_if

// ---- logic/dmaic_edge_det.sv ----
// per-channel request detector: low wait, transfer wait, high wait
`timescale 1ns/10ps
module dmaic_edge_det (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic en_in,
  input  wire logic active_in,
  input  wire logic edge_mode_in,
  input  wire logic taken_in,
  output logic      req_out
);
  import dmaic_pkg::*;
  dmaic_det_t st;
  dmaic_det_t next_st;
  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st)
      DET_LOW:  if (active_in) next_st = DET_XFER;
      DET_XFER: if (taken_in) next_st = edge_mode_in ? DET_HIGH : DET_LOW;
      DET_HIGH: if (!active_in) next_st = DET_LOW;
      default:  next_st = DET_LOW;
    endcase
    if (!en_in) next_st = DET_LOW;
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) st <= DET_LOW;
    else if (ce_in) st <= next_st;
  end
  assign req_out = st[1];   // transfer-wait bit of the one-hot code
endmodule : dmaic_edge_det

// ---- logic/dmaic_device.sv ----
// dma control end: registers, interrupt lines, request detection, cycle sequencing
`timescale 1ns/10ps
module dmaic_device #(
  parameter int MAR_W = 8
) (
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  dmaic_if.dev                           bus,
  input  wire logic [dmaic_pkg::NCH-1:0] req_n_in,
  input  wire logic [dmaic_pkg::NCH-1:0] int_src_in,
  input  wire logic                      nmi_in,
  input  wire logic                      cycle_end_in,
  input  wire logic                      wbuf_start_in,
  input  wire logic                      ext_busy_in,
  input  wire logic                      last_in,
  input  wire logic                      last_ext_in,
  input  wire logic                      ext_par_in,
  input  wire logic                      refresh_in,
  output logic                           bus_req_out,
  output logic                           addr_phase_out,
  output logic [2:0]                     chan_out,
  output logic [MAR_W-1:0]               mar_out,
  output logic [dmaic_pkg::NCH-1:0]      ack_n_out,
  output logic [1:0]                     end_n_out,
  output logic [dmaic_pkg::NCH-1:0]      src_clr_out
);
  import dmaic_pkg::*;
  if (MAR_W < 1 || MAR_W > DW) begin : g_chk
    $error("MAR_W must lie between 1 and the data width");
  end
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [DW-1:0]    ctrl [NCH];
  logic [DW-1:0]    mode;
  logic [DW-1:0]    route;
  logic [MAR_W-1:0] memory_address_reg [NCH];
  logic [NCH-1:0]   lock_xe, lock_me, req, en, taken, fin, transfer_finish_pin_lo;
  logic [NCH-1:0]   ie, xe, me, sc, isel, edm, bst;
  logic [7:0]       irq_next;
  logic [DW-1:0]    rd_next;
  dmaic_eng_t       st;
  logic             found;
  logic [2:0]       pick;
  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire stop     = mode[M_STOP];
  wire run      = ce_in & ~stop;
  wire full     = mode[M_FULL];
  wire shared   = mode[M_SHARED];
  wire acc_ok   = run | (bus.addr == A_MODE);
  wire wr_ok    = bus.wr & acc_ok & ce_in;
  wire rd_ok    = bus.rd & acc_ok & ce_in;
  wire is_ctrl  = (bus.addr < A_MODE);
  wire is_mar   = (bus.addr >= A_MAR0) && (bus.addr < A_STAT);
  wire [2:0] ci = bus.addr[2:0];
  wire [2:0] mi = 3'(bus.addr - A_MAR0);
  wire st_addr  = (st == ENG_ADDR);
  wire st_bus   = (st == ENG_BUS);
  wire cyc_done = cycle_end_in | (mode[M_WBE] & wbuf_start_in);
  wire any_en   = |xe;
  wire stop_w   = bus.wdata[M_STOP] & ~any_en;
  wire [DW-1:0] ctrl_rd = ctrl[ci];
  // channel currently on the bus, one-hot
  wire [NCH-1:0] g_sel_ack = NCH'(st_bus) << chan_out;
  // -----------------------------------------------------------------
  // per-channel control, lock, address and detector
  // -----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire wr_c  = wr_ok & is_ctrl & (ci == 3'(c));
    wire rd_c  = rd_ok & is_ctrl & (ci == 3'(c));
    wire here  = (chan_out == 3'(c));
    wire hw_xe = st_bus & here & cyc_done & last_in;
    wire hw_me = nmi_in & full & bst[c] & me[c];
    wire xe_w  = bus.wdata[B_XE] & ~lock_xe[c];
    wire me_w  = bus.wdata[B_ME] & ~lock_me[c];
    wire [DW-1:0] next_ctrl_w = {bus.wdata[7:3], me_w, xe_w, bus.wdata[0]};
    logic [DW-1:0] next_ctrl;
    assign ie[c]   = ctrl[c][B_IE];
    assign xe[c]   = ctrl[c][B_XE];
    assign me[c]   = ctrl[c][B_ME];
    assign sc[c]   = ctrl[c][B_SC];
    assign isel[c] = ctrl[c][B_INT];
    assign edm[c]  = ctrl[c][B_EDGE];
    assign bst[c]  = ctrl[c][B_BURST];
    assign en[c]   = xe[c] & (me[c] | ~full);
    assign taken[c] = st_addr & here;
    assign fin[c]  = st_bus & here & cyc_done & last_in & (last_ext_in | ~ext_par_in);
    always_comb begin
      next_ctrl = wr_c ? next_ctrl_w : ctrl[c];
      if (hw_xe) next_ctrl[B_XE] = 1'b0;                     // completion ends the channel
      if (hw_me) next_ctrl[B_ME] = 1'b0;
    end
    // control register and clear-then-read locks
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ctrl[c]    <= CTRL_RST;
        lock_xe[c] <= 1'b0;
        lock_me[c] <= 1'b0;
      end else if (ce_in) begin
        ctrl[c]    <= run ? next_ctrl : ctrl[c];
        lock_xe[c] <= (xe[c] & ~next_ctrl[B_XE] & run) | (lock_xe[c] & ~(rd_c & ~xe[c]));
        lock_me[c] <= (me[c] & ~next_ctrl[B_ME] & run) | (lock_me[c] & ~(rd_c & ~me[c]));
      end
    end
    // memory address, stepped in the address phase ahead of the bus cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) memory_address_reg[c] <= '0;
      else if (run && wr_ok && is_mar && mi == 3'(c)) memory_address_reg[c] <= bus.wdata[MAR_W-1:0];
      else if (run && taken[c]) memory_address_reg[c] <= memory_address_reg[c] + 1'b1;
    end
    dmaic_edge_det dmaic_edge_det_inst (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ce_in        (run),
      .en_in        (en[c]),
      .active_in    (isel[c] ? int_src_in[c] : ~req_n_in[c]),
      .edge_mode_in (edm[c]),
      .taken_in     (taken[c]),
      .req_out      (req[c])
    );
  end
  // -----------------------------------------------------------------
  // interrupt lines, bit 0 ranks highest
  // -----------------------------------------------------------------
  wire [NCH-1:0] endc = ie & ~xe;
  wire [NCH-1:0] brk  = ie & ~me & {NCH{full}};
  assign irq_next = shared
    ? (full ? {4'h0, brk[5], endc[5], brk[4], endc[4]}
            : {4'h0, endc[3], endc[2], endc[1], endc[0]})
    : {brk[5], endc[5], endc[3], endc[2], brk[4], endc[4], endc[1], endc[0]};
  // -----------------------------------------------------------------
  // channel pick in service order
  // -----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    pick  = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[PRIO[i]] && en[PRIO[i]]) begin
        found = 1'b1;
        pick  = 3'(PRIO[i]);
      end
    end
  end
  // cycle sequencer: idle, address phase, bus cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st       <= ENG_IDLE;
      chan_out <= 3'h0;
      mar_out  <= '0;
    end else if (run) begin
      case (st)
        ENG_IDLE: if (found) begin
          st       <= ENG_ADDR;
          chan_out <= pick;
        end
        ENG_ADDR: begin
          st      <= ENG_BUS;
          mar_out <= memory_address_reg[chan_out];
        end
        ENG_BUS: if (cyc_done) st <= ENG_IDLE;
        default: st <= ENG_IDLE;
      endcase
    end
  end
  assign addr_phase_out = st[1];
  assign bus_req_out    = st[2];
  // -----------------------------------------------------------------
  // read data, mode and route registers
  // -----------------------------------------------------------------
  assign rd_next = is_ctrl ? ctrl_rd :
                   (bus.addr == A_MODE)  ? mode :
                   (bus.addr == A_ROUTE) ? route :
                   is_mar ? DW'(memory_address_reg[mi]) :
                   (bus.addr == A_STAT)  ? {2'h0, xe & {NCH{bus_req_out}}} : irq_next;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode   <= MODE_RST;
      route  <= ROUTE_RST;
      bus.rdata <= '0;
    end else if (ce_in) begin
      if (wr_ok && bus.addr == A_MODE) mode <= {bus.wdata[7:6], stop_w, bus.wdata[4:0]};
      if (wr_ok && run && bus.addr == A_ROUTE) route <= bus.wdata;
      bus.rdata <= rd_ok ? rd_next : '0;
    end
  end
  // -----------------------------------------------------------------
  // pins and link outputs; all but src_clr_out keep working during stop
  // -----------------------------------------------------------------
  wire pin_a = shared ? (route[R_FOUR] ? transfer_finish_pin_lo[4] : route[R_ONE] & transfer_finish_pin_lo[1])
                      : (route[R_P0] ? transfer_finish_pin_lo[4] : transfer_finish_pin_lo[0]);
  wire pin_b = shared ? (route[R_FIVE] ? transfer_finish_pin_lo[5] : route[R_THREE] & transfer_finish_pin_lo[3])
                      : (route[R_P1] ? transfer_finish_pin_lo[5] : transfer_finish_pin_lo[1]);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      transfer_finish_pin_lo      <= '0;
      ack_n_out    <= '1;
      end_n_out    <= 2'h3;
      src_clr_out  <= '0;
      bus.irq      <= '0;
      bus.chan_en  <= '0;
      bus.ext_busy <= 1'b0;
      bus.int_pass <= '0;
    end else if (ce_in) begin
      transfer_finish_pin_lo      <= fin | (transfer_finish_pin_lo & {NCH{refresh_in & last_ext_in}});
      end_n_out    <= ~({pin_b, pin_a} & {2{mode[M_TEE]}});
      ack_n_out    <= ~(g_sel_ack & {NCH{mode[M_SAE] & ~full}});
      src_clr_out  <= {NCH{run & st_bus & cyc_done}} & g_sel_ack & sc & isel & xe;
      bus.irq      <= irq_next;
      bus.chan_en  <= xe;
      bus.ext_busy <= ext_busy_in;
      bus.int_pass <= int_src_in & ~(xe & sc & isel);
    end
  end
endmodule : dmaic_device

// ---- logic/dmaic_host.sv ----
// host end: software port, write screening, status registers
`timescale 1ns/10ps
module dmaic_host (
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  dmaic_if.host                          bus,
  input  wire logic [dmaic_pkg::AW:0]    sw_addr_in,
  input  wire logic [dmaic_pkg::DW-1:0]  sw_wdata_in,
  input  wire logic                      sw_wr_in,
  input  wire logic                      sw_rd_in,
  output logic [dmaic_pkg::DW-1:0]       sw_rdata_out,
  output logic [7:0]                     irq_out,
  output logic [dmaic_pkg::NCH-1:0]      cpu_irq_out
);
  import dmaic_pkg::*;
  logic [NCH-1:0] ie_sh;
  logic [2:0]     refused;
  logic [DW-1:0]  own_q;
  logic           dev_q;
  // -----------------------------------------------------------------
  // write screening
  // -----------------------------------------------------------------
  wire           dev_sel = ~sw_addr_in[AW];
  wire [AW-1:0]  da      = sw_addr_in[AW-1:0];
  wire [2:0]     ch      = da[2:0];
  wire           is_ctrl = dev_sel & (da < A_MODE);
  wire           act     = bus.chan_en[ch];
  wire           any_act = |bus.chan_en;
  wire r6  = is_ctrl & ~act & sw_wdata_in[B_IE] & ~sw_wdata_in[B_XE] & ~ie_sh[ch];
  wire r7  = (is_ctrl & act & sw_wdata_in[B_XE])
           | (dev_sel & (da > A_MODE) & (da < A_STAT) & any_act);
  wire r12 = dev_sel & (da == A_MODE) & (any_act | bus.ext_busy);
  wire refuse  = r6 | r7 | r12;
  wire [2:0] ev = {r12, r7, r6} & {3{sw_wr_in}};
  assign bus.wr    = sw_wr_in & dev_sel & ~refuse & ce_in;
  assign bus.rd    = sw_rd_in & dev_sel & ce_in;
  assign bus.addr  = da;
  assign bus.wdata = sw_wdata_in;
  wire clr_ref = sw_wr_in & (sw_addr_in == H_REFUSED);
  wire [DW-1:0] own_next = (sw_addr_in == H_REFUSED) ? {5'h00, refused} :
                           (sw_addr_in == H_IRQ) ? irq_out : DW'(cpu_irq_out);
  // -----------------------------------------------------------------
  // shadow, sticky refusal flags and outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ie_sh       <= '0;
      refused     <= 3'h0;
      own_q       <= '0;
      dev_q       <= 1'b0;
      irq_out     <= '0;
      cpu_irq_out <= '0;
    end else if (ce_in) begin
      if (bus.wr && is_ctrl) ie_sh[ch] <= sw_wdata_in[B_IE];
      refused     <= ev | (refused & ~({3{clr_ref}} & sw_wdata_in[2:0])); // set wins
      own_q       <= sw_rd_in ? own_next : '0;
      dev_q       <= sw_rd_in & dev_sel;
      irq_out     <= bus.irq;
      cpu_irq_out <= bus.int_pass;
    end
  end
  assign sw_rdata_out = dev_q ? bus.rdata : own_q;
endmodule : dmaic_host

// ---- sim/dmaic_chk.sv ----
// assertions on the link signals between the host end and the dma control end
`timescale 1ns/10ps
module dmaic_chk (
  input wire logic                      clk_in,
  input wire logic                      rst_n_in,
  input wire logic                      rd,
  input wire logic                      wr,
  input wire logic [dmaic_pkg::AW-1:0]  addr,
  input wire logic [dmaic_pkg::DW-1:0]  wdata,
  input wire logic [dmaic_pkg::DW-1:0]  rdata,
  input wire logic [7:0]                irq,
  input wire logic [dmaic_pkg::NCH-1:0] chan_en,
  input wire logic                      ext_busy,
  input wire logic [dmaic_pkg::NCH-1:0] int_pass
);
  import dmaic_pkg::*;
  // ----------------------------------------------------------------
  // mirror of mode and interrupt enables, both written only by software
  // ----------------------------------------------------------------
  logic [DW-1:0]  mode_q;
  logic [NCH-1:0] ie_q;
  logic [NCH-1:0] ie_d;    // enables as the irq flops saw them; chan_en lags xe by one flop
  wire            ctrl_wr = wr && addr < 4'h6 && !mode_q[M_STOP];
  wire [NCH-1:0]  ie_sel  = ctrl_wr ? 6'h01 << addr : 6'h00;
  wire [NCH-1:0]  next_ie = (ie_q & ~ie_sel) | (ie_sel & {NCH{wdata[B_IE]}});
  wire [NCH-1:0]  ends    = ie_d & ~chan_en;
  wire            rd_ie   = addr < 4'h6 ? ie_q[addr[2:0]] : 1'b0;
  wire            rd_xe   = addr < 4'h6 ? chan_en[addr[2:0]] : 1'b0;
  // mirror registers follow accepted link writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= MODE_RST;
      ie_q   <= 6'h00;
      ie_d   <= 6'h00;
    end else begin
      mode_q <= (wr && addr == A_MODE) ? wdata : mode_q;
      ie_q   <= next_ie;
      ie_d   <= ie_q;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // a control register read while the block runs
  sequence ctrl_read;
    rd && addr < 4'h6 && !mode_q[M_STOP];
  endsequence
  strobe_excl_a: assert property (!(rd && wr))
    else $error("read and write strobes together");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read");
  ctrl_readback_a: assert property (ctrl_read |=> rdata[B_IE] == $past(rd_ie) && rdata[B_XE] == $past(rd_xe))
    else $error("control read back wrong");
  stop_read_a: assert property (rd && mode_q[M_STOP] && addr != A_MODE |=> rdata == 8'h00)
    else $error("register readable in stop");
  mode_read_a: assert property (rd && addr == A_MODE |=> rdata[5:0] == $past(mode_q[5:0]))
    else $error("mode read back wrong");
  pc_end_a: assert property (!mode_q[M_SHARED] |=> {irq[6:4], irq[2:0]} == {ends[5], ends[3], ends[2], ends[4], ends[1], ends[0]})
    else $error("per-channel end lines wrong");
  pc_break_off_a: assert property (!mode_q[M_SHARED] && !mode_q[M_FULL] |=> !irq[3] && !irq[7])
    else $error("break line outside full mode");
  short_lines_a: assert property (mode_q[M_SHARED] && !mode_q[M_FULL] |=> irq == {4'h0, ends[3:0]})
    else $error("shared short lines wrong");
  full_lines_a: assert property (mode_q[M_SHARED] && mode_q[M_FULL] |=> irq[7:4] == 4'h0 && irq[0] == ends[4] && irq[2] == ends[5])
    else $error("shared full lines wrong");
endmodule : dmaic_chk

// ---- sim/dmaic_tb.sv ----
// self-checking bench joining the host end and the dma control end
`timescale 1ns/10ps
module dmaic_tb;
  import dmaic_pkg::*;
  logic                 clk_in, rst_n_in, ce_in, nmi_in, cycle_end_in, wbuf_start_in;
  logic                 ext_busy_in, last_in, last_ext_in, ext_par_in, refresh_in;
  logic                 sw_wr_in, sw_rd_in, bus_req_out, addr_phase_out;
  logic [NCH-1:0]       req_n_in, int_src_in, ack_n_out, src_clr_out, cpu_irq_out;
  logic [AW:0]          sw_addr_in;
  logic [DW-1:0]        sw_wdata_in, sw_rdata_out, irq_out, mar_out;
  logic [2:0]           chan_out;
  logic [1:0]           end_n_out;
  int                   mismatches, tests_run, c, i;
  int                   endpos [NCH] = '{0, 1, 2, 4, 5, 6};
  dmaic_if dmaic_if_inst ();
  dmaic_host dmaic_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .bus(dmaic_if_inst), .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
    .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
    .irq_out(irq_out), .cpu_irq_out(cpu_irq_out));
  dmaic_device dmaic_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .bus(dmaic_if_inst), .req_n_in(req_n_in), .int_src_in(int_src_in), .nmi_in(nmi_in),
    .cycle_end_in(cycle_end_in), .wbuf_start_in(wbuf_start_in), .ext_busy_in(ext_busy_in),
    .last_in(last_in), .last_ext_in(last_ext_in), .ext_par_in(ext_par_in),
    .refresh_in(refresh_in), .bus_req_out(bus_req_out), .addr_phase_out(addr_phase_out),
    .chan_out(chan_out), .mar_out(mar_out), .ack_n_out(ack_n_out), .end_n_out(end_n_out),
    .src_clr_out(src_clr_out));
  dmaic_chk dmaic_chk_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .rd(dmaic_if_inst.rd),
    .wr(dmaic_if_inst.wr), .addr(dmaic_if_inst.addr), .wdata(dmaic_if_inst.wdata),
    .rdata(dmaic_if_inst.rdata), .irq(dmaic_if_inst.irq), .chan_en(dmaic_if_inst.chan_en),
    .ext_busy(dmaic_if_inst.ext_busy), .int_pass(dmaic_if_inst.int_pass));
  // ----------------------------------------------------------------
  // access tasks and verdict
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [AW:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    sw_addr_in  <= a;
    sw_wdata_in <= d;
    sw_wr_in    <= 1'b1;
    @(posedge clk_in);
    sw_wr_in    <= 1'b0;
  endtask : wr_reg
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [AW:0] a, input logic [DW-1:0] exp);
    @(posedge clk_in);
    sw_addr_in <= a;
    sw_rd_in   <= 1'b1;
    @(posedge clk_in);
    sw_rd_in   <= 1'b0;
    #1;
    chk(sw_rdata_out, exp);
  endtask : rd_chk
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // 20 MHz clock and a watchdog well past the expected run
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #250000;
    mismatches++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_in, nmi_in, cycle_end_in, wbuf_start_in, ext_busy_in, ext_par_in} = 6'h00;
    {refresh_in, sw_wr_in, sw_rd_in, sw_addr_in, sw_wdata_in, int_src_in} = 22'h00_0000;
    {ce_in, last_in, last_ext_in, req_n_in} = 9'h1ff;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk(5'h06, MODE_RST);
    rd_chk(5'h00, CTRL_RST);
    rd_chk(5'h07, ROUTE_RST);
    // per-channel mode: each end line alone, in rank order
    wr_reg(5'h06, 8'h00);
    for (int k = 0; k < NCH; k++) begin
      c = PRIO[k];
      wr_reg(5'(c), 8'h03);
      wr_reg(5'(c), 8'h01);
      repeat (2) @(posedge clk_in);
      rd_chk(H_IRQ, 8'h01 << endpos[k]);
      wr_reg(5'(c), 8'h00);
      rd_chk(5'(c), 8'h00);
    end
    // enable bit relocks after falling until read as zero
    wr_reg(5'h02, 8'h02);
    wr_reg(5'h02, 8'h00);
    wr_reg(5'h02, 8'h02);
    rd_chk(5'h02, 8'h00);
    wr_reg(5'h02, 8'h02);
    rd_chk(5'h02, 8'h02);
    wr_reg(5'h02, 8'h00);
    rd_chk(5'h02, 8'h00);
    // shared short mode, stop refused while enabled, lines kept in stop
    wr_reg(5'h06, 8'h01);
    wr_reg(5'h01, 8'h03);
    wr_reg(5'h01, 8'h01);
    wr_reg(5'h00, 8'h02);
    wr_reg(5'h03, 8'h01);
    wr_reg(5'h06, 8'h21);
    rd_chk(H_REFUSED, 8'h05);
    rd_chk(5'h03, 8'h00);
    rd_chk(5'h06, 8'h01);
    wr_reg(5'h00, 8'h00);
    rd_chk(5'h00, 8'h00);
    wr_reg(H_REFUSED, 8'h07);
    wr_reg(5'h06, 8'h21);
    rd_chk(5'h06, 8'h21);
    rd_chk(5'h01, 8'h00);
    rd_chk(H_IRQ, 8'h02);
    wr_reg(5'h06, 8'h01);
    rd_chk(5'h01, 8'h01);
    wr_reg(5'h01, 8'h00);
    // full mode burst: non-maskable request drops master enable
    for (int t = 0; t < 2; t++) begin
      c = 4 + t;
      wr_reg(5'h06, t ? 8'h03 : 8'h02);
      wr_reg(5'(c), 8'h47);
      @(posedge clk_in);
      nmi_in <= 1'b1;
      @(posedge clk_in);
      nmi_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd_chk(H_IRQ, 8'h08);
      wr_reg(5'(c), 8'h00);
      rd_chk(5'(c), 8'h00);
    end
    // one transfer by pin and by internal source, end pin routing
    wr_reg(5'h06, 8'h0c);
    for (int t = 0; t < 2; t++) begin
      c = 4 * t;
      wr_reg(5'h07, t ? 8'h10 : 8'h00);
      wr_reg(5'(8 + c), 8'h10);
      if (t) int_src_in[4] <= 1'b1;
      else req_n_in[0] <= 1'b0;
      wr_reg(5'(c), t ? 8'h1b : 8'h03);
      for (i = 0; i < 20; i++) begin
        @(posedge clk_in);
        #1;
        if (addr_phase_out === 1'b1) break;
      end
      chk({5'h00, chan_out}, 8'(c));
      @(posedge clk_in);
      #1;
      chk({7'h00, bus_req_out}, 8'h01);
      chk(mar_out, 8'h10);
      chk({2'h0, cpu_irq_out}, 8'h00);
      @(posedge clk_in);
      cycle_end_in <= 1'b1;
      req_n_in     <= 6'h3f;
      @(posedge clk_in);
      cycle_end_in <= 1'b0;
      #1;
      chk({2'h0, src_clr_out}, t ? 8'h10 : 8'h00);
      chk({2'h0, ack_n_out}, t ? 8'h2f : 8'h3e);
      for (i = 0; i < 4; i++) begin
        @(posedge clk_in);
        #1;
        if (end_n_out[0] === 1'b0) break;
      end
      chk({6'h00, end_n_out}, 8'h02);
      rd_chk(5'(8 + c), 8'h11);
      rd_chk(5'(c), t ? 8'h19 : 8'h01);
      rd_chk(H_IRQ, t ? 8'h04 : 8'h01);
      rd_chk(H_PASS, t ? 8'h10 : 8'h00);
      int_src_in <= 6'h00;
      wr_reg(5'(c), 8'h00);
    end
    report_and_stop();
  end
endmodule : dmaic_tb
